// *** rtl/jisc_pkg.sv ***
// Behaviour
// RQ1: after power-up test pins are inputs, awaiting enable
// RQ2: blank device defaults port pins to test function
// RQ3: data output drives only after enable command
// RQ4: extension outputs enabled only by enable command
// RQ5: error output low on failed erase/program
// RQ6: error held until clear, or reset after disable
// RQ7: status output high while flash readable
// RQ8: status output low during program/erase/writes
// RQ9: enable command may select open-drain extension outputs
// RQ10: security bit refuses all memory read-out
// RQ11: secured port accepts only full chip erase
// RQ12: full chip erase clears security, leaves blank
// RQ13: protected sectors refuse erase requests
// RQ14: controller holds chip reset during programming
// RQ15: configuration commands only, no boundary scan
// RQ16: unprogrammed memory and configuration read as ones
// RQ17: extension pins stay undriven until enabled
package jisc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PROG_NS = 2000;
  localparam int unsigned ERASE_NS = 9000;
  localparam int unsigned PROG_CYC = (PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ERASE_CYC = (ERASE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned IR_W = 8;
  localparam int unsigned DR_W = 16;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
  localparam logic [IR_W-1:0] IR_ENABLE = 8'h0c;
  localparam logic [IR_W-1:0] IR_DISABLE = 8'h0f;
  localparam logic [IR_W-1:0] IR_CLEAR = 8'h10;
  localparam logic [IR_W-1:0] IR_PROGRAM = 8'h0a;
  localparam logic [IR_W-1:0] IR_ERASE = 8'h0b;
  localparam logic [IR_W-1:0] IR_FULL_ERASE = 8'h0d;
  localparam logic [IR_W-1:0] IR_READ = 8'h0e;
  localparam logic [IR_W-1:0] IR_BYPASS = 8'hff;
  localparam int unsigned OPT_EXT = 0;
  localparam int unsigned OPT_OD = 1;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PROTECT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_STAT = 8'h0c;
  localparam logic [7:0] REG_INT_MASK = 8'h10;
  localparam int unsigned CTRL_SECURE = 0;
  localparam int unsigned CTRL_PIN_JTAG = 1;
  localparam int unsigned INT_W = 4;
  localparam int unsigned INT_DONE = 0;
  localparam int unsigned INT_FAIL = 1;
  localparam int unsigned INT_REFUSED = 2;
  localparam int unsigned INT_ENABLED = 3;
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PAU_DR = 4'h5, TAP_EX2_DR = 4'h4,
    TAP_UPD_DR = 4'hc, TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SH_IR = 4'he,
    TAP_EX1_IR = 4'ha, TAP_PAU_IR = 4'hb, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
  } jisc_tap_type;
  typedef enum logic [1:0] {
    FOP_PROG = 2'h0, FOP_ERASE_SECT = 2'h1, FOP_ERASE_ALL = 2'h3
  } jisc_fop_type;
endpackage

// *** rtl/jisc_flash_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface jisc_flash_if;
  logic req;
  jisc_pkg::jisc_fop_type op;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic busy;
  logic done;
  logic fail;
  modport ctl (output req, op, addr, wdata, input rdata, busy, done, fail);
  modport flash (input req, op, addr, wdata, output rdata, busy, done, fail);
endinterface
`default_nettype wire

// *** rtl/jisc_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module jisc_sync #(
  parameter int unsigned WIDTH = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } jisc_sync_type;
  jisc_sync_type r, next_r;
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign q = r.s2;
endmodule
`default_nettype wire

// *** rtl/jisc_flash.sv ***
`timescale 1ns/100ps
`default_nettype none
module jisc_flash #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned SECT_BYTES = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request port
  jisc_flash_if.flash f
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned SW = $clog2(SECT_BYTES);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    jisc_pkg::jisc_fop_type op;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [jisc_pkg::CNT_W-1:0] cnt;
    logic busy;
    logic done;
    logic fail;
    logic [7:0] rdata;
  } jisc_flash_type;
  jisc_flash_type r, next_r;
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.fail = 1'b0;
    next_r.rdata = r.mem[f.addr[AW-1:0]];
    if (!r.busy && f.req) begin
      next_r.busy = 1'b1;
      next_r.op = f.op;
      next_r.addr = f.addr[AW-1:0];
      next_r.wdata = f.wdata;
      next_r.cnt = (f.op == jisc_pkg::FOP_PROG) ? jisc_pkg::CNT_W'(jisc_pkg::PROG_CYC - 1)
                                                : jisc_pkg::CNT_W'(jisc_pkg::ERASE_CYC - 1);
    end else if (r.busy && r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end else if (r.busy) begin
      next_r.busy = 1'b0;
      next_r.done = 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
        if (r.op == jisc_pkg::FOP_ERASE_ALL ||
            (r.op == jisc_pkg::FOP_ERASE_SECT && (i >> SW) == (r.addr >> SW))) begin
          next_r.mem[i] = 8'hff;
        end
      end
      // a cell only moves from one to zero; asking for a one over a zero fails
      if (r.op == jisc_pkg::FOP_PROG) begin
        if ((r.mem[r.addr] & r.wdata) != r.wdata) begin
          next_r.fail = 1'b1; // RQ5
        end else begin
          next_r.mem[r.addr] = r.wdata;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.mem <= '1; // RQ16
      r.rdata <= 8'hff;
    end else begin
      r <= next_r;
    end
  end
  assign f.busy = r.busy;
  assign f.done = r.done;
  assign f.fail = r.fail;
  assign f.rdata = r.rdata;
endmodule
`default_nettype wire

// *** rtl/jisc_port.sv ***
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module jisc_port #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned SECT_BYTES = 8,
  parameter int unsigned SECTORS = DEPTH / SECT_BYTES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe,
  // extension pins
  output logic flash_status_out,
  output logic flash_status_oe,
  output logic flash_error_out,
  output logic flash_error_oe,
  // chip reset pin and port function
  input wire logic chip_reset_n,
  output logic pin_jtag_func,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic tck_d;
    jisc_pkg::jisc_tap_type tap;
    logic [jisc_pkg::IR_W-1:0] ir;
    logic [jisc_pkg::IR_W-1:0] ir_sh;
    logic [jisc_pkg::DR_W-1:0] dr_sh;
    logic isc_en;
    logic ext_en;
    logic od;
    logic disabled;
    logic err;
    logic secure;
    logic full_pend;
    logic pin_jtag;
    logic [SECTORS-1:0] protect;
    logic [jisc_pkg::INT_W-1:0] int_stat;
    logic [jisc_pkg::INT_W-1:0] int_mask;
    logic freq;
    jisc_pkg::jisc_fop_type fop;
    logic [7:0] faddr;
    logic [7:0] fdata;
    logic tdo;
    logic tdo_oe;
    logic st_out;
    logic st_oe;
    logic er_out;
    logic er_oe;
    logic [31:0] prdata;
    logic pslverr;
  } jisc_port_type;

  localparam int unsigned SW = $clog2(SECT_BYTES);
  localparam int unsigned AW = $clog2(DEPTH);

  jisc_port_type r, next_r;
  logic [3:0] pins_s;
  logic tck_s, tms_s, tdi_s, rst_s;
  logic tck_rise, tck_fall;
  logic [jisc_pkg::INT_W-1:0] ev;
  logic [7:0] status_byte;
  logic bypass;
  logic setup, access;

  jisc_flash_if fif ();

  jisc_sync #(.WIDTH(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({chip_reset_n, tdi, tms, tck}),
    .q(pins_s)
  );

  jisc_flash #(.DEPTH(DEPTH), .SECT_BYTES(SECT_BYTES)) u_flash (
    .pclk(pclk),
    .presetn(presetn),
    .f(fif.flash)
  );

  assign tck_s = pins_s[0];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[2];
  assign rst_s = pins_s[3];
  // the link clock is sampled, so it must stay well below half of pclk
  assign tck_rise = tck_s && !r.tck_d;
  assign tck_fall = !tck_s && r.tck_d;
  assign status_byte = {1'b0, r.disabled, r.err, fif.busy, r.secure, r.od, r.ext_en, r.isc_en};
  // anything not in the configuration set falls back to a one-bit bypass
  assign bypass = !(r.ir inside {jisc_pkg::IR_ENABLE, jisc_pkg::IR_DISABLE, jisc_pkg::IR_CLEAR,
                                 jisc_pkg::IR_PROGRAM, jisc_pkg::IR_ERASE,
                                 jisc_pkg::IR_FULL_ERASE, jisc_pkg::IR_READ}); // RQ15
  assign setup = psel && !penable;
  assign access = psel && penable;

  function automatic jisc_pkg::jisc_tap_type tap_next(input jisc_pkg::jisc_tap_type s,
                                                      input logic m);
    case (s)
      jisc_pkg::TAP_RESET: tap_next = m ? jisc_pkg::TAP_RESET : jisc_pkg::TAP_IDLE;
      jisc_pkg::TAP_IDLE: tap_next = m ? jisc_pkg::TAP_SEL_DR : jisc_pkg::TAP_IDLE;
      jisc_pkg::TAP_SEL_DR: tap_next = m ? jisc_pkg::TAP_SEL_IR : jisc_pkg::TAP_CAP_DR;
      jisc_pkg::TAP_CAP_DR: tap_next = m ? jisc_pkg::TAP_EX1_DR : jisc_pkg::TAP_SH_DR;
      jisc_pkg::TAP_SH_DR: tap_next = m ? jisc_pkg::TAP_EX1_DR : jisc_pkg::TAP_SH_DR;
      jisc_pkg::TAP_EX1_DR: tap_next = m ? jisc_pkg::TAP_UPD_DR : jisc_pkg::TAP_PAU_DR;
      jisc_pkg::TAP_PAU_DR: tap_next = m ? jisc_pkg::TAP_EX2_DR : jisc_pkg::TAP_PAU_DR;
      jisc_pkg::TAP_EX2_DR: tap_next = m ? jisc_pkg::TAP_UPD_DR : jisc_pkg::TAP_SH_DR;
      jisc_pkg::TAP_UPD_DR: tap_next = m ? jisc_pkg::TAP_SEL_DR : jisc_pkg::TAP_IDLE;
      jisc_pkg::TAP_SEL_IR: tap_next = m ? jisc_pkg::TAP_RESET : jisc_pkg::TAP_CAP_IR;
      jisc_pkg::TAP_CAP_IR: tap_next = m ? jisc_pkg::TAP_EX1_IR : jisc_pkg::TAP_SH_IR;
      jisc_pkg::TAP_SH_IR: tap_next = m ? jisc_pkg::TAP_EX1_IR : jisc_pkg::TAP_SH_IR;
      jisc_pkg::TAP_EX1_IR: tap_next = m ? jisc_pkg::TAP_UPD_IR : jisc_pkg::TAP_PAU_IR;
      jisc_pkg::TAP_PAU_IR: tap_next = m ? jisc_pkg::TAP_EX2_IR : jisc_pkg::TAP_PAU_IR;
      jisc_pkg::TAP_EX2_IR: tap_next = m ? jisc_pkg::TAP_UPD_IR : jisc_pkg::TAP_SH_IR;
      jisc_pkg::TAP_UPD_IR: tap_next = m ? jisc_pkg::TAP_SEL_DR : jisc_pkg::TAP_IDLE;
      default: tap_next = jisc_pkg::TAP_RESET;
    endcase
  endfunction

  always_comb begin
    next_r = r;
    ev = '0;
    next_r.tck_d = tck_s;
    next_r.freq = 1'b0;

    // serial state machine advances on the sampled rising edge of the link clock
    if (tck_rise) begin
      next_r.tap = tap_next(r.tap, tms_s);
      case (r.tap)
        jisc_pkg::TAP_RESET: begin
          next_r.ir = jisc_pkg::IR_BYPASS;
        end
        jisc_pkg::TAP_CAP_IR: begin
          next_r.ir_sh = jisc_pkg::IR_CAPTURE;
        end
        jisc_pkg::TAP_SH_IR: begin
          next_r.ir_sh = {tdi_s, r.ir_sh[jisc_pkg::IR_W-1:1]};
        end
        jisc_pkg::TAP_UPD_IR: begin
          next_r.ir = r.ir_sh;
        end
        jisc_pkg::TAP_CAP_DR: begin
          if (r.ir == jisc_pkg::IR_READ) begin
            // secured parts shift out zeros instead of memory contents
            next_r.dr_sh = {r.faddr, r.secure ? 8'h00 : fif.rdata}; // RQ10
          end else begin
            next_r.dr_sh = {8'h00, status_byte};
          end
        end
        jisc_pkg::TAP_SH_DR: begin
          if (bypass) begin
            next_r.dr_sh[0] = tdi_s;
          end else begin
            next_r.dr_sh = {tdi_s, r.dr_sh[jisc_pkg::DR_W-1:1]};
          end
        end
        jisc_pkg::TAP_UPD_DR: begin
          if (r.ir == jisc_pkg::IR_ENABLE) begin
            next_r.isc_en = 1'b1; // RQ3
            next_r.ext_en = r.dr_sh[jisc_pkg::OPT_EXT]; // RQ4
            next_r.od = r.dr_sh[jisc_pkg::OPT_OD]; // RQ9
            next_r.disabled = 1'b0;
            ev[jisc_pkg::INT_ENABLED] = 1'b1;
          end else if (!r.isc_en) begin
            // nothing but the enable command is honoured before enable
            next_r.isc_en = 1'b0; // RQ1
          end else if (r.ir == jisc_pkg::IR_DISABLE) begin
            next_r.isc_en = 1'b0;
            next_r.ext_en = 1'b0;
            next_r.disabled = 1'b1;
          end else if (r.ir == jisc_pkg::IR_CLEAR) begin
            next_r.err = 1'b0; // RQ6
          end else if (r.ir == jisc_pkg::IR_FULL_ERASE) begin
            if (!fif.busy) begin
              next_r.freq = 1'b1;
              next_r.fop = jisc_pkg::FOP_ERASE_ALL;
              next_r.full_pend = 1'b1;
            end else begin
              ev[jisc_pkg::INT_REFUSED] = 1'b1;
            end
          end else if (r.secure && !bypass) begin
            ev[jisc_pkg::INT_REFUSED] = 1'b1; // RQ11
          end else if (r.ir == jisc_pkg::IR_READ) begin
            next_r.faddr = r.dr_sh[15:8];
          end else if (r.ir == jisc_pkg::IR_PROGRAM || r.ir == jisc_pkg::IR_ERASE) begin
            next_r.faddr = r.dr_sh[15:8];
            next_r.fdata = r.dr_sh[7:0];
            if (fif.busy) begin
              ev[jisc_pkg::INT_REFUSED] = 1'b1;
            end else if (r.ir == jisc_pkg::IR_PROGRAM) begin
              next_r.freq = 1'b1;
              next_r.fop = jisc_pkg::FOP_PROG;
            end else if (r.protect[r.dr_sh[8+AW-1:8+SW]]) begin
              ev[jisc_pkg::INT_REFUSED] = 1'b1; // RQ13
            end else begin
              next_r.freq = 1'b1;
              next_r.fop = jisc_pkg::FOP_ERASE_SECT;
            end
          end
        end
        default: begin
          next_r.tap = tap_next(r.tap, tms_s);
        end
      endcase
    end

    // output data changes on the falling edge so the controller samples it stable
    if (tck_fall) begin
      next_r.tdo = (r.tap == jisc_pkg::TAP_SH_IR) ? r.ir_sh[0] : r.dr_sh[0];
    end
    next_r.tdo_oe = r.isc_en; // RQ3

    // flash completion
    if (fif.done) begin
      ev[jisc_pkg::INT_DONE] = 1'b1;
      if (r.full_pend) begin
        next_r.secure = 1'b0; // RQ12
        next_r.pin_jtag = 1'b1; // RQ2
        next_r.full_pend = 1'b0;
      end
    end
    // chip reset after disable releases the error; the programmer keeps
    // the chip reset low during programming, so only a disabled port sees it
    if (!rst_s && r.disabled) begin
      next_r.err = 1'b0; // RQ6 RQ14
    end
    // a failure in the same cycle as a clear still lands
    if (fif.fail) begin
      next_r.err = 1'b1; // RQ5
      ev[jisc_pkg::INT_FAIL] = 1'b1;
    end

    // extension pins: push-pull drives both levels, open-drain only pulls low
    next_r.st_out = r.od ? 1'b0 : !fif.busy; // RQ7 RQ8
    next_r.st_oe = r.ext_en && (!r.od || fif.busy); // RQ9 RQ17
    next_r.er_out = r.od ? 1'b0 : !r.err; // RQ5
    next_r.er_oe = r.ext_en && (!r.od || r.err); // RQ4 RQ17

    // apb: read data and error are prepared in the setup cycle
    if (setup) begin
      next_r.pslverr = 1'b0;
      case (paddr)
        jisc_pkg::REG_CTRL: next_r.prdata = 32'({r.pin_jtag, r.secure});
        jisc_pkg::REG_PROTECT: next_r.prdata = 32'(r.protect);
        jisc_pkg::REG_STATUS: next_r.prdata = 32'(status_byte);
        jisc_pkg::REG_INT_STAT: next_r.prdata = 32'(r.int_stat);
        jisc_pkg::REG_INT_MASK: next_r.prdata = 32'(r.int_mask);
        default: begin
          next_r.prdata = 32'h0000_0000;
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    if (access && pwrite) begin
      case (paddr)
        jisc_pkg::REG_CTRL: begin
          // the security bit is set by software and only a full erase clears it
          if (pwdata[jisc_pkg::CTRL_SECURE]) begin
            next_r.secure = 1'b1;
          end
          next_r.pin_jtag = pwdata[jisc_pkg::CTRL_PIN_JTAG];
        end
        jisc_pkg::REG_PROTECT: next_r.protect = pwdata[SECTORS-1:0];
        jisc_pkg::REG_INT_STAT: next_r.int_stat = r.int_stat & ~pwdata[jisc_pkg::INT_W-1:0];
        jisc_pkg::REG_INT_MASK: next_r.int_mask = pwdata[jisc_pkg::INT_W-1:0];
        default: begin
          next_r.int_mask = r.int_mask;
        end
      endcase
    end
    // events win over a simultaneous write-one-to-clear
    next_r.int_stat = next_r.int_stat | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.tap <= jisc_pkg::TAP_RESET;
      r.ir <= jisc_pkg::IR_BYPASS;
      r.pin_jtag <= 1'b1; // RQ2 RQ16
      r.fop <= jisc_pkg::FOP_PROG;
      r.st_out <= 1'b1;
      r.er_out <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign fif.req = r.freq;
  assign fif.op = r.fop;
  assign fif.addr = r.faddr;
  assign fif.wdata = r.fdata;

  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = r.pslverr && access;
  assign tdo_out = r.tdo;
  assign tdo_oe = r.tdo_oe;
  assign flash_status_out = r.st_out;
  assign flash_status_oe = r.st_oe;
  assign flash_error_out = r.er_out;
  assign flash_error_oe = r.er_oe;
  assign pin_jtag_func = r.pin_jtag;
  assign irq = |(r.int_stat & r.int_mask);
endmodule
`default_nettype wire

// *** testbench/jisc_port_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module jisc_port_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  input wire logic tck,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  // extension and port pins
  input wire logic flash_status_out,
  input wire logic flash_status_oe,
  input wire logic flash_error_out,
  input wire logic flash_error_oe,
  input wire logic pin_jtag_func
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_released;
    $rose(presetn);
  endsequence
  sequence s_status_fall;
    $fell(flash_status_out) && flash_status_oe;
  endsequence
  sequence s_error_fall;
    $fell(flash_error_out) && flash_error_oe;
  endsequence

  property p_link_quiet;
    s_released |-> !tdo_oe [*8];
  endproperty
  a_link_quiet: assert property (p_link_quiet)
    else $error("tdo driven right after reset");
  property p_ext_quiet;
    s_released |-> (!flash_status_oe && !flash_error_oe) [*8];
  endproperty
  a_ext_quiet: assert property (p_ext_quiet)
    else $error("extension pins driven right after reset");
  property p_test_pins;
    s_released |-> pin_jtag_func;
  endproperty
  a_test_pins: assert property (p_test_pins)
    else $error("port pins not in serial test function");
  // tdo may only move in the low half of tck so the far side samples it on the rise
  property p_tdo_on_fall;
    tdo_oe && $past(tdo_oe) && $changed(tdo_out) |-> !tck && !$past(tck);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("tdo changed while tck high");
  property p_error_holds;
    s_error_fall |-> !flash_error_out [*8];
  endproperty
  a_error_holds: assert property (p_error_holds)
    else $error("error pin released too early");
  property p_busy_min;
    s_status_fall |-> !flash_status_out [*8];
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("status pin low for too short a time");
  property p_busy_bounded;
    s_status_fall |-> ##[1:1000] (flash_status_out || !flash_status_oe);
  endproperty
  a_busy_bounded: assert property (p_busy_bounded)
    else $error("status pin never returned to ready");
  property p_push_pull_pair;
    flash_status_oe && flash_status_out |-> flash_error_oe;
  endproperty
  a_push_pull_pair: assert property (p_push_pull_pair)
    else $error("status driven high without push-pull error pin");
endmodule

bind jisc_port jisc_port_assertions u_chk (.pclk(pclk), .presetn(presetn), .tck(tck),
  .tdo_out(tdo_out), .tdo_oe(tdo_oe), .flash_status_out(flash_status_out),
  .flash_status_oe(flash_status_oe), .flash_error_out(flash_error_out),
  .flash_error_oe(flash_error_oe), .pin_jtag_func(pin_jtag_func));
`default_nettype wire

// *** testbench/jisc_jtag_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module jisc_jtag_host (
  // clock
  input wire logic pclk,
  // serial link
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  // chip reset pin
  output logic chip_reset_n
);
  logic o;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    chip_reset_n = 1'b1;
  end

  // one 160 ns period; tck rests low outside frames, tdo taken just before the rise
  task automatic tick(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge pclk);
    o = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge pclk);
    tck <= 1'b0;
  endtask

  task automatic tap_reset();
    repeat (5) tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
  endtask

  // idle to idle, lsb first; tdi toggles when not shifting so no stale bit looks valid
  task automatic scan(input logic ir, input logic [15:0] d, input int n, output logic [15:0] q);
    q = 16'h0;
    tick(1'b1, ~tdi);
    if (ir) tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
    tick(1'b0, ~tdi);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i]);
      q[i] = o;
    end
    tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
  endtask

  task automatic enable(input logic [15:0] opts);
    logic [15:0] q;
    scan(1'b1, {8'h00, jisc_pkg::IR_ENABLE}, 8, q);
    scan(1'b0, opts, 16, q);
  endtask

  task automatic hold_core(input logic released);
    chip_reset_n <= released;
  endtask
endmodule
`default_nettype wire

// *** testbench/jisc_port_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module jisc_port_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic tck, tms, tdi, tdo_out, tdo_oe, chip_reset_n, pin_jtag_func;
  logic flash_status_out, flash_status_oe, flash_error_out, flash_error_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] q;
  int n_mismatch, n_checks, cycles;
  // tdo floats high through a pull-up when the port does not drive it
  wire logic tdo_pin = tdo_oe ? tdo_out : 1'b1;

  jisc_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .flash_status_out(flash_status_out), .flash_status_oe(flash_status_oe),
    .flash_error_out(flash_error_out), .flash_error_oe(flash_error_oe),
    .chip_reset_n(chip_reset_n), .pin_jtag_func(pin_jtag_func), .irq(irq));
  jisc_jtag_host u_host (.pclk(pclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin),
    .chip_reset_n(chip_reset_n));

  always #5 pclk = ~pclk;

  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, r & m);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [15:0] d);
    u_host.scan(1'b1, {8'h00, op}, 8, q);
    u_host.scan(1'b0, d, 16, q);
  endtask

  task automatic wait_ready();
    int t;
    t = 0;
    while (flash_status_oe === 1'b1 && flash_status_out === 1'b0 && t < 3000) begin
      @(posedge pclk);
      t++;
    end
    repeat (2) @(posedge pclk);
    check("ready wait", 32'h0, t >= 3000);
  endtask

  task automatic read_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    cmd(jisc_pkg::IR_READ, {a, 8'h00});
    u_host.scan(1'b0, {a, 8'h00}, 16, q);
    check(name, {a, exp}, q);
  endtask

  task automatic t_reset();
    check("tdo_oe", 32'h0, tdo_oe);
    check("ext oe", 32'h0, {flash_status_oe, flash_error_oe});
    check("pin_jtag_func", 32'h1, pin_jtag_func);
    rd("ctrl", jisc_pkg::REG_CTRL, 32'h3, 32'h2);
    rd("protect", jisc_pkg::REG_PROTECT, 32'hff, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h1, {r[7:0], e});
    u_host.tap_reset();
    cmd(jisc_pkg::IR_PROGRAM, 16'h3000);
    check("tdo_oe idle", 32'h0, tdo_oe);
    rd("status idle", jisc_pkg::REG_STATUS, 32'h13, 32'h0);
  endtask

  task automatic t_enable();
    u_host.enable(16'h0001);
    repeat (4) @(posedge pclk);
    check("tdo_oe on", 32'h1, tdo_oe);
    check("ext pins", 32'hf, {flash_status_oe, flash_status_out, flash_error_oe,
      flash_error_out});
    rd("status on", jisc_pkg::REG_STATUS, 32'h7, 32'h3);
    check("irq masked", 32'h0, irq);
    apb(1'b1, jisc_pkg::REG_INT_MASK, 32'h8);
    check("irq raised", 32'h1, irq);
    apb(1'b1, jisc_pkg::REG_INT_STAT, 32'h8);
    check("irq cleared", 32'h0, irq);
  endtask

  task automatic t_program();
    u_host.hold_core(1'b0);
    u_host.scan(1'b1, {8'h00, jisc_pkg::IR_PROGRAM}, 8, q);
    check("ir capture", 32'h1, q[7:0]);
    u_host.scan(1'b0, 16'h305a, 16, q);
    repeat (2) @(posedge pclk);
    check("status busy", 32'h0, flash_status_out);
    wait_ready();
    check("status ready", 32'h1, flash_status_out);
    rd("int done", jisc_pkg::REG_INT_STAT, 32'h3, 32'h1);
    read_chk("read back", 8'h30, 8'h5a);
    cmd(jisc_pkg::IR_PROGRAM, 16'h30ff);
    wait_ready();
    check("error low", 32'h0, flash_error_out);
    repeat (40) @(posedge pclk);
    check("error held", 32'h0, flash_error_out);
    cmd(jisc_pkg::IR_CLEAR, 16'h0000);
    check("error cleared", 32'h1, flash_error_out);
    apb(1'b1, jisc_pkg::REG_INT_STAT, 32'hf);
  endtask

  task automatic t_protect();
    apb(1'b1, jisc_pkg::REG_PROTECT, 32'h01);
    cmd(jisc_pkg::IR_ERASE, 16'h0200);
    rd("erase refused", jisc_pkg::REG_STATUS, 32'h30, 32'h0);
    rd("refused int", jisc_pkg::REG_INT_STAT, 32'h7, 32'h4);
    cmd(jisc_pkg::IR_ERASE, 16'h0800);
    check("erase busy", 32'h0, flash_status_out);
    wait_ready();
    apb(1'b1, jisc_pkg::REG_INT_STAT, 32'hf);
  endtask

  task automatic t_secure();
    apb(1'b1, jisc_pkg::REG_CTRL, 32'h1);
    cmd(jisc_pkg::IR_PROGRAM, 16'h3100);
    rd("secure idle", jisc_pkg::REG_STATUS, 32'h18, 32'h8);
    rd("secure int", jisc_pkg::REG_INT_STAT, 32'h7, 32'h4);
    read_chk("secure read", 8'h08, 8'h00);
    cmd(jisc_pkg::IR_FULL_ERASE, 16'h0000);
    wait_ready();
    rd("unsecured", jisc_pkg::REG_STATUS, 32'h8, 32'h0);
    rd("blank ctrl", jisc_pkg::REG_CTRL, 32'h3, 32'h2);
    read_chk("blank", 8'h30, 8'hff);
  endtask

  task automatic t_open_drain();
    u_host.enable(16'h0003);
    repeat (4) @(posedge pclk);
    check("od idle", 32'h0, {flash_status_oe, flash_status_out, flash_error_oe});
    cmd(jisc_pkg::IR_PROGRAM, 16'h3100);
    check("od busy", 32'h2, {flash_status_oe, flash_status_out});
    wait_ready();
    cmd(jisc_pkg::IR_PROGRAM, 16'h31ff);
    wait_ready();
    check("od error", 32'h2, {flash_error_oe, flash_error_out});
  endtask

  task automatic t_disable();
    u_host.hold_core(1'b1);
    cmd(jisc_pkg::IR_DISABLE, 16'h0000);
    repeat (4) @(posedge pclk);
    check("tdo released", 32'h0, tdo_oe);
    rd("error kept", jisc_pkg::REG_STATUS, 32'h60, 32'h60);
    u_host.hold_core(1'b0);
    repeat (8) @(posedge pclk);
    rd("error reset", jisc_pkg::REG_STATUS, 32'h20, 32'h0);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    n_checks = 0;
    cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_enable();
    t_program();
    t_protect();
    t_secure();
    t_open_drain();
    t_disable();
    print_verdict();
  end
endmodule
`default_nettype wire
